/* hw/ilo_decode.v */
// How it works
// RL1: the subtract-and-return op takes a 6-bit literal 0..63 off the frame pointer, flags untouched.
// RL2: after the pointer update it returns by loading the program counter from the stack top.
// RL3: the op lasts two instruction cycles, the second one a no-operation.
// RL4: it is the subtract-from-pointer opcode 1110 1001 with select field 11, frame pointer only.
// RL5: enabling the extension also turns on indexed literal offset addressing of file operands.
// RL6: with extension off, address is access bank when a=0 and the bank pointer's bank when a=1.
// RL7: with extension on and a=0, operands up to 5Fh are offsets from the frame pointer.
// RL8: a frame pointer of zero maps offsets onto the original access-bank addresses.
// RL9: offset mode address is frame pointer plus offset 0..95, destination bit unchanged.
// RL10: with extension on, a=0 operands above 5Fh and all a=1 operands stay literal.
`include "ilo_defs.vh"
module ilo_decode #(
	parameter Q_PHASES = 4
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// decode results
	output reg [11:0] eff_addr,
	output reg offset_mode,
	output reg dest_bit,
	output reg busy
);
	// one-hot sequencer states
	localparam ST_IDLE = 3'b001;
	localparam ST_EXEC = 3'b010;
	localparam ST_NOP = 3'b100;

	// sequencer position within the op and within the instruction cycle
	reg [2:0] state;
	reg [1:0] qph;
	// programmer-visible state of the core slice
	reg ext_enable;
	reg [11:0] frame_pointer;
	reg [3:0] bank_select_pointer;
	reg [20:0] return_stack_top;
	reg [20:0] prog_counter;
	reg [15:0] opword;
	// completed subtract-and-return ops, wraps at 8 bits
	reg [7:0] ret_count;
	// read decode and the word it selects
	reg bad_addr;
	reg [31:0] rd_mux;
	// effective address from the operand calculator
	wire [11:0] calc_addr;
	wire calc_offset;
	// bus qualifiers
	wire wr_en;
	wire rd_en;
	wire reg_wr;
	// sequencing strobes
	wire q_end;
	wire is_subret;
	wire launch;
	wire exec_done;
	wire nop_done;

	// apb qualifiers; registers only take writes while no op runs
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign reg_wr = wr_en && !bad_addr && (state == ST_IDLE);
	// zero wait states: every access ends in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && bad_addr;

	// last q phase of the current instruction cycle
	assign q_end = (qph == Q_PHASES - 1);
	// opcode 1110 1001 11kk kkkk on the incoming operand word
	assign is_subret = (pwdata[15:8] == `ILO_OP_SUBLIT_HI) &&
		(pwdata[`ILO_SEL_HI:`ILO_SEL_LO] == `ILO_SEL_RETURN); // RL4
	// other select codes of the same opcode only load the operand
	assign launch = reg_wr && (paddr == `ILO_REG_OPER) && is_subret; // RL4
	// the first instruction cycle does the work, the second idles
	assign exec_done = (state == ST_EXEC) && q_end; // RL3
	assign nop_done = (state == ST_NOP) && q_end; // RL3

	// operand address calculator, shared by every byte/bit-oriented operand
	ilo_addr_calc i_ilo_addr_calc (
		.ext_enable(ext_enable),
		.access_sel(opword[`ILO_ABIT]),
		.file_field(opword[7:0]),
		.frame_pointer(frame_pointer),
		.bank_select_pointer(bank_select_pointer),
		.eff_addr(calc_addr),
		.offset_mode(calc_offset)
	);

	// read decode; unmapped offsets flag an error and read as zero
	always @* begin
		bad_addr = 1'b0;
		rd_mux = 32'h00000000;
		if (paddr == `ILO_REG_CTRL) begin
			rd_mux = {31'h0, ext_enable};
		end else if (paddr == `ILO_REG_FP) begin
			rd_mux = {20'h0, frame_pointer};
		end else if (paddr == `ILO_REG_BSP) begin
			rd_mux = {28'h0, bank_select_pointer};
		end else if (paddr == `ILO_REG_TOS) begin
			rd_mux = {11'h0, return_stack_top};
		end else if (paddr == `ILO_REG_OPER) begin
			rd_mux = {16'h0, opword};
		end else if (paddr == `ILO_REG_EADDR) begin
			rd_mux = {19'h0, offset_mode, eff_addr};
		end else if (paddr == `ILO_REG_PC) begin
			rd_mux = {11'h0, prog_counter};
		end else if (paddr == `ILO_REG_STAT) begin
			rd_mux = {21'h0, ret_count, busy, state[2:1]};
		end else begin
			bad_addr = 1'b1;
		end
	end

	// read data is caught in the setup cycle and stands through the access cycle,
	// so the bus sees a flip-flop and not the decode tree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			prdata <= rd_mux;
		end
	end

	// q-phase counter; a launch restarts it so the op owns whole instruction cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qph <= 2'h0;
		end else if (launch) begin
			qph <= 2'h0;
		end else if (q_end) begin
			qph <= 2'h0;
		end else begin
			qph <= qph + 2'h1;
		end
	end

	// two-cycle sequencer; busy stands from launch to the end of the idle cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			busy <= 1'b0;
			ret_count <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (launch) begin
						state <= ST_EXEC; // RL4
						busy <= 1'b1;
					end
				end
				ST_EXEC: begin
					// pointer and program counter change at the last q phase
					if (exec_done) begin
						state <= ST_NOP; // RL3
					end
				end
				ST_NOP: begin
					// second instruction cycle: pointers hold; only ret_count, busy and state change, at its last q phase
					if (nop_done) begin
						ret_count <= ret_count + 8'h01; // RL3
						busy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// software-visible registers; the op's pointer update and return land together
	// at the end of its first instruction cycle, and no status flags exist to touch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_enable <= 1'b0;
			frame_pointer <= `ILO_FP_RST;
			bank_select_pointer <= `ILO_BSP_RST;
			return_stack_top <= `ILO_TOS_RST;
			prog_counter <= `ILO_PC_RST;
			opword <= `ILO_OPER_RST;
		end else if (exec_done) begin
			frame_pointer <= frame_pointer - {6'h00, opword[`ILO_LIT_HI:0]}; // RL1
			prog_counter <= return_stack_top; // RL2
		end else if (reg_wr) begin
			// read-only and unmapped offsets fall through untouched
			if (paddr == `ILO_REG_CTRL) begin
				ext_enable <= pwdata[0]; // RL5
			end else if (paddr == `ILO_REG_FP) begin
				frame_pointer <= pwdata[11:0];
			end else if (paddr == `ILO_REG_BSP) begin
				bank_select_pointer <= pwdata[3:0];
			end else if (paddr == `ILO_REG_TOS) begin
				return_stack_top <= pwdata[20:0];
			end else if (paddr == `ILO_REG_PC) begin
				prog_counter <= pwdata[20:0];
			end else if (paddr == `ILO_REG_OPER) begin
				opword <= pwdata[15:0];
			end
		end
	end

	// operand results follow the operand or a pointer change one cycle later;
	// the destination bit passes through untouched in either addressing mode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_addr <= 12'h000;
			offset_mode <= 1'b0;
			dest_bit <= 1'b0;
		end else begin
			eff_addr <= calc_addr; // RL9
			offset_mode <= calc_offset; // RL7
			dest_bit <= opword[`ILO_DBIT]; // RL9
		end
	end
endmodule // ilo_decode

/* hw/ilo_defs.vh */
`ifndef ILO_DEFS_VH
`define ILO_DEFS_VH
// opcode matching
`define ILO_OP_SUBLIT_HI 8'hE9
`define ILO_SEL_HI 7
`define ILO_SEL_LO 6
`define ILO_SEL_RETURN 2'h3
`define ILO_LIT_HI 5
// byte/bit-oriented operand fields
`define ILO_ABIT 8
`define ILO_DBIT 9
`define ILO_OFFSET_MAX 8'h5F
`define ILO_ACCESS_HI_BASE 12'hF00
// apb register map
`define ILO_REG_CTRL 12'h000
`define ILO_REG_FP 12'h004
`define ILO_REG_BSP 12'h008
`define ILO_REG_TOS 12'h00C
`define ILO_REG_OPER 12'h010
`define ILO_REG_EADDR 12'h014
`define ILO_REG_PC 12'h018
`define ILO_REG_STAT 12'h01C
// reset values
`define ILO_FP_RST 12'h000
`define ILO_PC_RST 21'h000000
`define ILO_BSP_RST 4'h0
`define ILO_TOS_RST 21'h000000
`define ILO_OPER_RST 16'h0000
// timing
`define ILO_CYC_SUBRET 2
`endif

/* hw/ilo_addr_calc.v */
`include "ilo_defs.vh"
// effective data address for a byte/bit-oriented file operand
module ilo_addr_calc (
	// operand
	input wire ext_enable,
	input wire access_sel,
	input wire [7:0] file_field,
	// pointers
	input wire [11:0] frame_pointer,
	input wire [3:0] bank_select_pointer,
	// result
	output reg [11:0] eff_addr,
	output reg offset_mode
);
	// selects literal, banked or offset addressing
	always @* begin
		offset_mode = ext_enable && !access_sel && (file_field <= `ILO_OFFSET_MAX); // RL5 RL7
		if (offset_mode) begin
			eff_addr = frame_pointer + {4'h0, file_field}; // RL9 RL8
		end else if (access_sel) begin
			eff_addr = {bank_select_pointer, file_field}; // RL6 RL10
		end else if (file_field <= `ILO_OFFSET_MAX) begin
			eff_addr = {4'h0, file_field}; // RL6
		end else begin
			eff_addr = `ILO_ACCESS_HI_BASE | {4'h0, file_field}; // RL6 RL10
		end
	end
endmodule // ilo_addr_calc

/* verification/ilo_decode_chk.sv */
module ilo_decode_chk (
	input wire pclk, presetn, psel, penable, pwrite, offset_mode, dest_bit, busy,
	input wire [11:0] paddr, eff_addr,
	input wire [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	wire wr = psel && penable && pwrite && !busy;
	reg ext;
	reg [3:0] bsp;
	reg [11:0] fp;
	reg [15:0] op;
	wire offm = ext && !op[8] && op[7:0] <= 8'h5F;
	wire [11:0] lit = op[8] ? {bsp, op[7:0]} : {(op[7:0] > 8'h5F) ? 4'hF : 4'h0, op[7:0]};
	// shadow of the registers that steer the address
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ext, bsp, fp, op} <= 33'h0;
		end else begin
			if ($fell(busy)) fp <= fp - {6'h00, op[5:0]};
			if (wr) begin
			case (paddr)
			12'h000: ext <= pwdata[0];
			12'h004: fp <= pwdata[11:0];
			12'h008: bsp <= pwdata[3:0];
			12'h010: op <= pwdata[15:0];
			default: ;
			endcase
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence launch_s; wr && paddr == 12'h010 && pwdata[15:6] == 10'h3A7; endsequence
	sequence calm_s; !busy && !$past(busy) && !$past(wr); endsequence
	run_len_a: assert property (launch_s |=> busy [*8] ##1 !busy) else $error("busy span");
	run_end_a: assert property ($fell(busy) |-> $past(busy, 8)) else $error("short run");
	busy_cause_a: assert property ($rose(busy) |-> $past(wr && paddr == 12'h010))
		else $error("stray busy");
	no_launch_a: assert property (wr && paddr == 12'h010 && pwdata[7:6] != 2'h3 |=> !busy)
		else $error("false launch");
	dest_copy_a: assert property (wr && paddr == 12'h010 |=> ##1 dest_bit == $past(pwdata[9], 2))
		else $error("dest bit");
	mode_pick_a: assert property (calm_s |-> offset_mode == offm) else $error("mode");
	lit_addr_a: assert property (calm_s ##0 !offm |-> eff_addr == lit)
		else $error("literal address");
	off_addr_a: assert property (calm_s ##0 offm |-> eff_addr == fp + {4'h0, op[7:0]})
		else $error("offset address");
endmodule // ilo_decode_chk
bind ilo_decode ilo_decode_chk i_ilo_decode_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.offset_mode, .dest_bit, .busy, .paddr, .eff_addr, .pwdata);

/* verification/ilo_decode_bench.sv */
module ilo_decode_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, offset_mode, dest_bit, busy, rerr;
	logic [11:0] eff_addr;
	int bad_count = 0, compares = 0;
	always #5 pclk = ~pclk;
	ilo_decode i_ilo_decode (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .eff_addr, .offset_mode, .dest_bit, .busy);
	task complete_run;
		if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %0t got %h want %h", $time, s, e);
		end
	endtask
	// one apb transfer, held until pready
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask
	// launch a subtract-and-return and wait it out
	task ret(input logic [5:0] k, input logic [31:0] f, input logic [31:0] t);
		xfer(1'b1, 12'h00C, t);
		xfer(1'b1, 12'h010, {16'h0, 10'h3A7, k});
		@(posedge pclk);
		chk({31'h0, busy}, 32'h1);
		// a pointer write while the op runs must be ignored
		xfer(1'b1, 12'h004, 32'hFFF);
		while (busy === 1'b1) @(posedge pclk);
		rd(12'h004, f);
		rd(12'h018, t);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b1, 12'h008, 32'h3);
		xfer(1'b1, 12'h010, 32'h0145);
		rd(12'h014, 32'h345);
		xfer(1'b1, 12'h010, 32'h0080);
		rd(12'h014, 32'hF80);
		xfer(1'b1, 12'h000, 32'h1);
		xfer(1'b1, 12'h010, 32'h0220);
		rd(12'h014, 32'h1020);
		chk({31'h0, dest_bit}, 32'h1);
		xfer(1'b1, 12'h010, 32'h0060);
		rd(12'h014, 32'hF60);
		xfer(1'b1, 12'h010, 32'h0120);
		rd(12'h014, 32'h320);
		xfer(1'b1, 12'h004, 32'h3FF);
		xfer(1'b1, 12'h010, 32'h005F);
		rd(12'h014, 32'h145E);
		xfer(1'b1, 12'h00C, 32'h100);
		xfer(1'b1, 12'h010, 32'hE9A3);
		rd(12'h004, 32'h3FF);
		ret(6'h23, 32'h3DC, 32'h100);
		ret(6'h3F, 32'h39D, 32'h1234);
		rd(12'h01C, 32'h10);
		rd(12'h020, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		complete_run;
	end
	// watchdog, well past the hundred or so cycles the tests need
	initial begin
		#20000;
		bad_count++;
		complete_run;
	end
endmodule // ilo_decode_bench
